//--- verilog/halfbridge_fault_spi_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "hb_cfg.svh"

// Function
// - Latch thermal warning, keep outputs active
// - Thermal warning cleared only over SPI
// - Shutdown temperature latches flag, outputs off
// - Outputs off while shutdown flag set
// - Load undervoltage: outputs off, flag latched
// - Outputs resume when undervoltage ends
// - Overvoltage: outputs off, latched, auto resume
// - Select bit picks second overvoltage pair
// - Logic undervoltage resets, outputs high impedance
// - Power-up flag reads 0 after reset
// - Filtered undercurrent latches per-switch openload
// - Openload sets load error, output unchanged
// - Disable bit masks freewheeling openload
// - Accept 16-bit word on serial input
// - Sample on falling, shift on rising
// - Decode and tristate on select release
// - In-frame response of addressed register
// - Byte-wise access; controller clears flags
// - Ignore frames before enable setup time
// - Serve single slave and daisy chain
// - LSB first, address then data byte
// - Operation bit set clears status bits
// - Before first rise, output error OR input
module halfbridge_fault_spi_ctrl #(
    parameter int NCH           = 8,
    parameter int OL_FILTER_CYC = `HB_OL_FILTER_CYC,
    parameter int TSET_CYC      = `HB_TSET_CYC
) (
    input  wire logic           clk_i,
    input  wire logic           rstn_i,
    input  wire logic           en_i,
    input  wire logic           temp_warn_i,
    input  wire logic           temp_shutdown_i,
    input  wire logic           load_uv_i,
    input  wire logic           load_ov1_i,
    input  wire logic           load_ov2_i,
    input  wire logic [NCH-1:0] hs_undercurrent_i,
    input  wire logic [NCH-1:0] ls_undercurrent_i,
    input  wire logic [NCH-1:0] freewheel_i,
    input  wire logic           chip_select_n_i,
    input  wire logic           sclk_i,
    input  wire logic           sdi_i,
    output logic                sdo_o,
    output logic                sdo_oe_o,
    output logic [NCH-1:0]      hs_drive_o,
    output logic [NCH-1:0]      ls_drive_o,
    output logic                global_error_indication_o
);
    import hb_pkg::*;

    localparam int SW  = 9 + 3 * NCH;
    localparam int OLW = $clog2(OL_FILTER_CYC + 1);
    localparam int TSW = $clog2(TSET_CYC + 1);

    if (NCH != 8 || OL_FILTER_CYC < 1 || TSET_CYC < 1) begin : g_chk
        $error("NCH must be 8 and cycle counts at least 1");
    end

    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    logic [SW-1:0]  sync_q;
    logic           en_s, csn_s, sclk_s, sdi_s;
    logic           tw_s, tsd_s, uv_s, ov1_s, ov2_s;
    logic [NCH-1:0] hs_uc_s, ls_uc_s, fw_s;

    // Chip select idles high so reset does not fake a frame start
    hb_sync2 #(
        .W    (SW),
        .INIT (SW'(2))
    ) u_sync (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .d_i    ({freewheel_i, ls_undercurrent_i, hs_undercurrent_i, load_ov2_i, load_ov1_i,
                  load_uv_i, temp_shutdown_i, temp_warn_i, sdi_i, sclk_i, chip_select_n_i, en_i}),
        .q_o    (sync_q)
    );

    assign {fw_s, ls_uc_s, hs_uc_s, ov2_s, ov1_s, uv_s, tsd_s, tw_s, sdi_s, sclk_s, csn_s, en_s} = sync_q;

    logic sclk_d, csn_d;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sclk_d <= 1'b0;
            csn_d  <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
            csn_d  <= csn_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d;
    assign sclk_fall = ~sclk_s & sclk_d;
    assign cs_fall   = ~csn_s & csn_d;
    assign cs_rise   = csn_s & ~csn_d;

    // ----------------------------------------------------------------
    // Enable setup time
    // ----------------------------------------------------------------
    logic [TSW-1:0] tset_cnt;
    logic           en_ready;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tset_cnt <= '0;
        end else if (!en_s) begin
            tset_cnt <= '0;
        end else if (tset_cnt != TSW'(TSET_CYC)) begin
            tset_cnt <= tset_cnt + 1'b1;
        end
    end

    assign en_ready = (tset_cnt == TSW'(TSET_CYC));

    // ----------------------------------------------------------------
    // Registers and flags
    // ----------------------------------------------------------------
    byte_t          hs_en, ls_en, cfg;
    logic           thermal_warning_flag, thermal_shutdown_flag, uv, ov, not_powered_up_flag, le;
    logic [NCH-1:0] hs_ol, ls_ol;
    byte_t          status;
    logic           global_error_indication;
    logic           ov_live, stage_ok;
    logic           cmd_valid;
    logic [15:0]    cmd_word;
    logic [4:0]     cmd_addr;
    logic           cmd_op;
    byte_t          cmd_data;
    logic           clr_glob, clr_hs, clr_ls;
    logic [2*NCH-1:0] ol_hit;

    assign cmd_addr = cmd_word[`HB_ADDR_MSB:`HB_ADDR_LSB];
    assign cmd_op   = cmd_word[`HB_OP_BIT];
    assign cmd_data = cmd_word[15:8];
    assign clr_glob = cmd_valid & cmd_op & (cmd_addr == `HB_ADDR_STATUS);
    assign clr_hs   = cmd_valid & cmd_op & (cmd_addr == `HB_ADDR_HS_OL);
    assign clr_ls   = cmd_valid & cmd_op & (cmd_addr == `HB_ADDR_LS_OL);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hs_en <= `HB_RST_BYTE;
            ls_en <= `HB_RST_BYTE;
            cfg   <= `HB_RST_BYTE;
        end else if (cmd_valid && cmd_op) begin
            if (cmd_addr == `HB_ADDR_HS_EN) begin
                hs_en <= cmd_data;
            end else if (cmd_addr == `HB_ADDR_LS_EN) begin
                ls_en <= cmd_data;
            end else if (cmd_addr == `HB_ADDR_CFG) begin
                cfg <= cmd_data;
            end
        end
    end

    assign ov_live = cfg[`HB_CFG_ALT_OV] ? ov2_s : ov1_s;

    // A fault still present in the clearing cycle re-sets its flag
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            thermal_warning_flag  <= 1'b0;
            thermal_shutdown_flag  <= 1'b0;
            uv   <= 1'b0;
            ov   <= 1'b0;
            le   <= 1'b0;
            not_powered_up_flag <= 1'b0;
        end else begin
            thermal_warning_flag  <= tw_s | (thermal_warning_flag & ~clr_glob);
            thermal_shutdown_flag  <= tsd_s | (thermal_shutdown_flag & ~clr_glob);
            uv   <= uv_s | (uv & ~clr_glob);
            ov   <= ov_live | (ov & ~clr_glob);
            le   <= (|ol_hit) | (le & ~clr_glob);
            not_powered_up_flag <= not_powered_up_flag | clr_glob;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hs_ol <= '0;
            ls_ol <= '0;
        end else begin
            hs_ol <= ol_hit[NCH-1:0] | (hs_ol & ~{NCH{clr_hs}});
            ls_ol <= ol_hit[2*NCH-1:NCH] | (ls_ol & ~{NCH{clr_ls}});
        end
    end

    always_comb begin
        status              = `HB_RST_BYTE;
        status[`HB_ST_TPW]  = thermal_warning_flag;
        status[`HB_ST_TSD]  = thermal_shutdown_flag;
        status[`HB_ST_NOT_POWERED_UP_FLAG] = not_powered_up_flag;
        status[`HB_ST_OV]   = ov;
        status[`HB_ST_UV]   = uv;
        status[`HB_ST_LE]   = le;
    end

    assign global_error_indication = thermal_warning_flag | thermal_shutdown_flag | ~not_powered_up_flag | ov | uv | le;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            global_error_indication_o <= 1'b1;
        end else begin
            global_error_indication_o <= global_error_indication;
        end
    end

    // ----------------------------------------------------------------
    // Output stage gating
    // ----------------------------------------------------------------
    // Undervoltage and overvoltage gate from the live level so the stages
    // return by themselves; thermal shutdown gates from the latched flag.
    assign stage_ok = en_s & ~thermal_shutdown_flag & ~uv_s & ~ov_live;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hs_drive_o <= '0;
            ls_drive_o <= '0;
        end else begin
            hs_drive_o <= stage_ok ? hs_en : '0;
            ls_drive_o <= stage_ok ? ls_en : '0;
        end
    end

    // ----------------------------------------------------------------
    // Open load filter, one counter per switch
    // ----------------------------------------------------------------
    logic [2*NCH-1:0] ol_watch;

    assign ol_watch = {ls_drive_o, hs_drive_o} & {ls_uc_s, hs_uc_s}
                      & ~({fw_s, fw_s} & {2*NCH{cfg[`HB_CFG_FW_DIS]}});

    for (genvar i = 0; i < 2 * NCH; i++) begin : g_ol
        logic [OLW-1:0] cnt;

        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                cnt <= '0;
            end else if (!ol_watch[i]) begin
                cnt <= '0;
            end else if (cnt != OLW'(OL_FILTER_CYC)) begin
                cnt <= cnt + 1'b1;
            end
        end

        // Output is left as it is: openload only reports
        assign ol_hit[i] = ol_watch[i] && (cnt == OLW'(OL_FILTER_CYC));
    end

    // ----------------------------------------------------------------
    // Serial link
    // ----------------------------------------------------------------
    spi_state_e  state;
    logic [5:0]  bit_cnt;
    logic [15:0] rx, tx, next_rx;
    logic        started;
    byte_t       rd_data;
    logic [4:0]  rd_addr;
    logic        len_ok;

    assign next_rx = {sdi_s, rx[15:1]};
    // Seven bits in: the address field sits at the top of the shifter
    assign rd_addr = next_rx[`HB_FRAME_BITS - 1:`HB_FRAME_BITS - 1 - `HB_ADDR_MSB + `HB_ADDR_LSB];
    assign len_ok  = (bit_cnt >= 6'(`HB_FRAME_BITS)) && (bit_cnt[2:0] == 3'h0);

    always_comb begin
        if (rd_addr == `HB_ADDR_STATUS) begin
            rd_data = status;
        end else if (rd_addr == `HB_ADDR_HS_EN) begin
            rd_data = hs_en;
        end else if (rd_addr == `HB_ADDR_LS_EN) begin
            rd_data = ls_en;
        end else if (rd_addr == `HB_ADDR_CFG) begin
            rd_data = cfg;
        end else if (rd_addr == `HB_ADDR_HS_OL) begin
            rd_data = hs_ol;
        end else if (rd_addr == `HB_ADDR_LS_OL) begin
            rd_data = ls_ol;
        end else begin
            rd_data = `HB_RST_BYTE;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state     <= ST_IDLE;
            bit_cnt   <= '0;
            rx        <= '0;
            tx        <= '0;
            started   <= 1'b0;
            sdo_o     <= 1'b0;
            sdo_oe_o  <= 1'b0;
            cmd_valid <= 1'b0;
            cmd_word  <= '0;
        end else begin
            cmd_valid <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (cs_fall) begin
                        bit_cnt <= '0;
                        started <= 1'b0;
                        if (en_ready) begin
                            state    <= ST_FRAME;
                            tx       <= {`HB_RST_BYTE, status};
                            sdo_o    <= global_error_indication | sdi_s;
                            sdo_oe_o <= 1'b1;
                        end else begin
                            state <= ST_SKIP;
                        end
                    end
                end
                ST_FRAME: begin
                    if (cs_rise) begin
                        state     <= ST_IDLE;
                        sdo_o     <= 1'b0;
                        sdo_oe_o  <= 1'b0;
                        cmd_valid <= len_ok && rx[`HB_START_BIT];
                        cmd_word  <= rx;
                    end else if (sclk_rise) begin
                        started <= 1'b1;
                        sdo_o   <= tx[1];
                        // Received bits trail the response for daisy chains
                        tx      <= {rx[15], tx[15:1]};
                    end else if (sclk_fall) begin
                        rx <= next_rx;
                        if (bit_cnt != 6'h3f) begin
                            bit_cnt <= bit_cnt + 1'b1;
                        end
                        // Load on the last address bit: the eighth rise already sends D0
                        if (bit_cnt == 6'(`HB_ADDR_MSB)) begin
                            tx[8:1] <= rd_data;
                        end
                    end else if (!started) begin
                        sdo_o <= global_error_indication | sdi_s;
                    end
                end
                ST_SKIP: begin
                    if (cs_rise) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

//--- inc/hb_cfg.svh
`ifndef HB_CFG_SVH
`define HB_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HB_CLK_MHZ        20
`define HB_OL_FILTER_NS   200000
`define HB_OL_FILTER_CYC  ((`HB_OL_FILTER_NS * `HB_CLK_MHZ + 999) / 1000)
`define HB_TSET_NS        10000
`define HB_TSET_CYC       ((`HB_TSET_NS * `HB_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define HB_FRAME_BITS     16
`define HB_ADDR_LSB       2
`define HB_ADDR_MSB       6
`define HB_OP_BIT         7
`define HB_START_BIT      0

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define HB_ADDR_STATUS    5'h00
`define HB_ADDR_HS_EN     5'h01
`define HB_ADDR_LS_EN     5'h02
`define HB_ADDR_CFG       5'h03
`define HB_ADDR_HS_OL     5'h04
`define HB_ADDR_LS_OL     5'h05

// ----------------------------------------------------------------
// Global status bits, config bits, reset values
// ----------------------------------------------------------------
`define HB_ST_TPW         1
`define HB_ST_TSD         2
`define HB_ST_NOT_POWERED_UP_FLAG        3
`define HB_ST_OV          4
`define HB_ST_UV          5
`define HB_ST_LE          6
`define HB_CFG_ALT_OV     0
`define HB_CFG_FW_DIS     1
`define HB_RST_BYTE       8'h00

`endif

//--- inc/hb_pkg.sv
package hb_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FRAME,
        ST_SKIP
    } spi_state_e;

    typedef logic [7:0] byte_t;

endpackage

//--- verilog/hb_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module hb_sync2 #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta <= INIT;
            q_o  <= INIT;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule

`default_nettype wire

//--- testbench/hb_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none

module hb_ctrl_props #(
    parameter int NCH           = 8,
    parameter int OL_FILTER_CYC = 8,
    parameter int TSET_CYC      = 4
) (
    input  wire logic           clk_i,
    input  wire logic           rstn_i,
    input  wire logic           en_i,
    input  wire logic           temp_warn_i,
    input  wire logic           temp_shutdown_i,
    input  wire logic           load_uv_i,
    input  wire logic           load_ov1_i,
    input  wire logic           load_ov2_i,
    input  wire logic [NCH-1:0] hs_undercurrent_i,
    input  wire logic [NCH-1:0] ls_undercurrent_i,
    input  wire logic [NCH-1:0] freewheel_i,
    input  wire logic           chip_select_n_i,
    input  wire logic           sclk_i,
    input  wire logic           sdi_i,
    input  wire logic           sdo_o,
    input  wire logic           sdo_oe_o,
    input  wire logic [NCH-1:0] hs_drive_o,
    input  wire logic [NCH-1:0] ls_drive_o,
    input  wire logic           global_error_indication_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // ----------------------------------------------------------------
    // Open-load watch on channel 0
    // ----------------------------------------------------------------
    logic [15:0] ol_cnt;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ol_cnt <= '0;
        end else if (hs_undercurrent_i[0] && hs_drive_o[0] && !freewheel_i[0]) begin
            ol_cnt <= ol_cnt + 16'h0001;
        end else begin
            ol_cnt <= '0;
        end
    end

    sequence s_tsd_hit;
        $rose(temp_shutdown_i) ##6 1'b1;
    endsequence
    sequence s_uv_long;
        load_uv_i [*6];
    endsequence
    sequence s_frame_end;
        $rose(chip_select_n_i);
    endsequence

    property p_rst_state;
        $rose(rstn_i) |-> (hs_drive_o == '0 && ls_drive_o == '0 && !sdo_oe_o && global_error_indication_o);
    endproperty
    property p_warn_keep;
        $rose(temp_warn_i) && chip_select_n_i |=> $stable(hs_drive_o) [*6];
    endproperty
    property p_gef_warn;
        temp_warn_i [*6] |-> global_error_indication_o;
    endproperty
    property p_tsd_off;
        $rose(temp_shutdown_i) |-> ##[1:6] (hs_drive_o == '0 && ls_drive_o == '0);
    endproperty
    property p_tsd_hold;
        s_tsd_hit |-> (hs_drive_o == '0 && ls_drive_o == '0) [*8];
    endproperty
    property p_uv_off;
        s_uv_long |-> (hs_drive_o == '0 && ls_drive_o == '0);
    endproperty
    property p_ov_off;
        (load_ov1_i && load_ov2_i) [*6] |-> (hs_drive_o == '0 && ls_drive_o == '0);
    endproperty
    property p_ol_flag;
        ol_cnt == 16'(OL_FILTER_CYC + 6) |-> global_error_indication_o ##1 hs_drive_o[0];
    endproperty
    property p_sdo_release;
        s_frame_end |-> ##[1:5] (!sdo_oe_o && !sdo_o);
    endproperty
    property p_frame_open;
        $rose(sdo_oe_o) |-> sdo_o == (global_error_indication_o | $past(sdi_i, 3));
    endproperty

    a_rst_state:   assert property (p_rst_state)   else $error("outputs not in reset state");
    a_warn_keep:   assert property (p_warn_keep)   else $error("drives moved on warning");
    a_gef_warn:    assert property (p_gef_warn)    else $error("warning not flagged");
    a_tsd_off:     assert property (p_tsd_off)     else $error("stages on after shutdown");
    a_tsd_hold:    assert property (p_tsd_hold)    else $error("stages back without clear");
    a_uv_off:      assert property (p_uv_off)      else $error("stages on in undervoltage");
    a_ov_off:      assert property (p_ov_off)      else $error("stages on in overvoltage");
    a_ol_flag:     assert property (p_ol_flag)     else $error("open load not reported");
    a_sdo_release: assert property (p_sdo_release) else $error("serial out not released");
    a_frame_open:  assert property (p_frame_open)  else $error("frame start bit wrong");
endmodule

bind halfbridge_fault_spi_ctrl hb_ctrl_props #(.NCH(NCH), .OL_FILTER_CYC(OL_FILTER_CYC), .TSET_CYC(TSET_CYC)) u_props (
    .clk_i(clk_i), .rstn_i(rstn_i), .en_i(en_i), .temp_warn_i(temp_warn_i), .temp_shutdown_i(temp_shutdown_i),
    .load_uv_i(load_uv_i), .load_ov1_i(load_ov1_i), .load_ov2_i(load_ov2_i), .hs_undercurrent_i(hs_undercurrent_i),
    .ls_undercurrent_i(ls_undercurrent_i), .freewheel_i(freewheel_i), .chip_select_n_i(chip_select_n_i),
    .sclk_i(sclk_i), .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .hs_drive_o(hs_drive_o),
    .ls_drive_o(ls_drive_o), .global_error_indication_o(global_error_indication_o));

`default_nettype wire

//--- testbench/hb_spi_master.sv
`timescale 1ns/1ps
`default_nettype none

module hb_spi_master (
    input  wire logic clk_i,
    input  wire logic sdo_i,
    output logic      chip_select_n_o,
    output logic      sclk_o,
    output logic      sdi_o
);
    initial begin
        chip_select_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
    end

    // ----------------------------------------------------------------
    // One 16-bit frame, 400 ns serial period, clock low at select edges
    // ----------------------------------------------------------------
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        @(negedge clk_i);
        sdi_o = 1'b0; // Low ahead of select so bit 0 carries the error flag alone
        @(negedge clk_i);
        chip_select_n_o = 1'b0;
        repeat (4) @(negedge clk_i);
        rx[0] = sdo_i;
        for (int i = 0; i < 16; i++) begin
            sclk_o = 1'b1;
            sdi_o = tx[i];
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b0;
            if (i < 15) begin
                rx[i+1] = sdo_i;
            end
            repeat (4) @(negedge clk_i);
        end
        chip_select_n_o = 1'b1;
        // Released line must not keep the last bit: show its inverse
        sdi_o = ~sdi_o;
        repeat (4) @(negedge clk_i);
    endtask
endmodule

`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import hb_pkg::*;
    localparam int NCH = 8;
    localparam int OLF = 8;
    localparam int TSET = 4;

    logic           clk_i, rstn_i, en_i, tw, ts, uv, ov1, ov2;
    logic [NCH-1:0] hs_uc, ls_uc, fw, hs_drv, ls_drv;
    logic           chip_select_n, sclk, sdi, sdo, sdo_oe, global_error_indication;
    logic [15:0]    rx;
    int             error_cnt, num_checks, cycles;

    halfbridge_fault_spi_ctrl #(.NCH(NCH), .OL_FILTER_CYC(OLF), .TSET_CYC(TSET)) dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .en_i(en_i), .temp_warn_i(tw), .temp_shutdown_i(ts),
        .load_uv_i(uv), .load_ov1_i(ov1), .load_ov2_i(ov2), .hs_undercurrent_i(hs_uc),
        .ls_undercurrent_i(ls_uc), .freewheel_i(fw), .chip_select_n_i(chip_select_n), .sclk_i(sclk), .sdi_i(sdi),
        .sdo_o(sdo), .sdo_oe_o(sdo_oe), .hs_drive_o(hs_drv), .ls_drive_o(ls_drv), .global_error_indication_o(global_error_indication));
    hb_spi_master m (.clk_i(clk_i), .sdo_i(sdo), .chip_select_n_o(chip_select_n), .sclk_o(sclk), .sdi_o(sdi));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic w(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Address byte: start bit, last-byte token, register address, operation
    task automatic frame(input logic [4:0] a, input logic op, input byte_t d);
        m.xfer({d, op, a, 2'b11}, rx);
        w(6);
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_power_up;
        frame(5'h00, 1'b0, 8'h00);
        chk(rx, 16'h0001);
        chk(16'(global_error_indication), 16'h0001);
        frame(5'h00, 1'b1, 8'h00);
        chk(16'(global_error_indication), 16'h0000);
        frame(5'h00, 1'b0, 8'h00);
        chk(rx, 16'h0808);
        $display("Test power_up done");
    endtask
    task automatic t_enables;
        frame(5'h01, 1'b1, 8'ha5);
        frame(5'h02, 1'b1, 8'h5a);
        chk(16'(rx[15:8]), 16'h0000);
        chk({hs_drv, ls_drv}, 16'ha55a);
        frame(5'h01, 1'b0, 8'h00);
        chk(16'(rx[15:8]), 16'h00a5);
        $display("Test enables done");
    endtask
    task automatic t_thermal;
        tw = 1'b1;
        w(10);
        chk({hs_drv, ls_drv}, 16'ha55a);
        tw = 1'b0;
        w(10);
        frame(5'h00, 1'b0, 8'h00);
        chk(rx, 16'h0a0b);
        ts = 1'b1;
        w(10);
        chk({hs_drv, ls_drv}, 16'h0000);
        ts = 1'b0;
        w(20);
        frame(5'h01, 1'b0, 8'h00);
        chk(16'(rx[15:8]), 16'h00a5);
        chk({hs_drv, ls_drv}, 16'h0000);
        frame(5'h00, 1'b1, 8'h00);
        chk({hs_drv, ls_drv}, 16'ha55a);
        $display("Test thermal done");
    endtask
    task automatic t_supply;
        uv = 1'b1;
        w(10);
        chk({hs_drv, ls_drv}, 16'h0000);
        frame(5'h00, 1'b1, 8'h00);
        frame(5'h00, 1'b0, 8'h00);
        chk(rx, 16'h2829);
        uv = 1'b0;
        w(10);
        chk({hs_drv, ls_drv}, 16'ha55a);
        ov1 = 1'b1;
        w(10);
        chk({hs_drv, ls_drv}, 16'h0000);
        ov1 = 1'b0;
        ov2 = 1'b1;
        w(10);
        chk({hs_drv, ls_drv}, 16'ha55a);
        ov2 = 1'b0;
        frame(5'h03, 1'b1, 8'h01);
        ov1 = 1'b1;
        w(10);
        chk({hs_drv, ls_drv}, 16'ha55a);
        ov2 = 1'b1;
        w(10);
        chk({hs_drv, ls_drv}, 16'h0000);
        ov1 = 1'b0;
        ov2 = 1'b0;
        w(10);
        frame(5'h00, 1'b1, 8'h00);
        chk(16'(global_error_indication), 16'h0000);
        $display("Test supply done");
    endtask
    task automatic t_openload;
        frame(5'h03, 1'b1, 8'h02);
        hs_uc = 8'h05;
        ls_uc = 8'h02;
        fw = 8'h04;
        w(OLF + 20);
        chk({hs_drv, ls_drv}, 16'ha55a);
        frame(5'h04, 1'b0, 8'h00);
        chk(rx, 16'h0149);
        frame(5'h05, 1'b0, 8'h00);
        chk(16'(rx[15:8]), 16'h0002);
        hs_uc = '0;
        ls_uc = '0;
        fw = '0;
        frame(5'h04, 1'b1, 8'h00);
        frame(5'h00, 1'b1, 8'h00);
        frame(5'h04, 1'b0, 8'h00);
        chk(rx, 16'h0008);
        $display("Test openload done");
    endtask
    task automatic t_en_setup;
        en_i = 1'b0;
        w(5);
        en_i = 1'b1;
        w(1);
        frame(5'h01, 1'b1, 8'hff);
        chk(rx, 16'h0000);
        chk(16'(hs_drv), 16'h00a5);
        $display("Test en_setup done");
    endtask
    task automatic t_mid_reset;
        rstn_i = 1'b0;
        w(3);
        chk({hs_drv, ls_drv}, 16'h0000);
        chk(16'(global_error_indication), 16'h0001);
        rstn_i = 1'b1;
        w(TSET + 6);
        frame(5'h01, 1'b0, 8'h00);
        chk(rx, 16'h0001);
        $display("Test mid_reset done");
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    initial begin
        {rstn_i, tw, ts, uv, ov1, ov2} = '0;
        en_i = 1'b1;
        {hs_uc, ls_uc, fw} = '0;
        error_cnt = 0;
        num_checks = 0;
        cycles = 0;
        w(10);
        rstn_i = 1'b1;
        w(TSET + 6);
        t_power_up();
        t_enables();
        t_thermal();
        t_supply();
        t_openload();
        t_en_setup();
        t_mid_reset();
        tally_and_finish();
    end
endmodule

`default_nettype wire
